// ==== design/dmsc_consts.svh ====
// constants of the deinterlacer mode and sync control
// Function
// - after reset the block passes video through without external memory
// - pass-through forwards active pixels unchanged and drops blanking beats
// - streaming ports stall while data cannot advance, resume on handshake
// - output stalled over about 1000 clocks flags output overrun and error event
// - input stalled too long flags input overrun
// - overrun errors only arise while the matching port is enabled
// - raster size and mode latch, lock begins at next frame start
// - lock shows on a pin, an event pulse and a status level
// - while deinterlacing every input pixel yields two output pixels
// - faults either drop lock or raise a buffer error, told apart
// - evaluation build zeroes output pixels after about eight hours
// - control reset low blocks start and cancels arming, but does not drop lock
// - start is taken only while the control clock enable is high
`ifndef DMSC_CONSTS_SVH
`define DMSC_CONSTS_SVH
`define DMSC_CLK_HZ 64'd20000000
`define DMSC_OUT_STALL_CLKS 1000
`define DMSC_IN_STALL_CLKS 1000
`define DMSC_EVAL_HOURS 64'd8
`define DMSC_EVAL_CYCLES (`DMSC_EVAL_HOURS * 64'd3600 * `DMSC_CLK_HZ)
`define DMSC_DIM_RST 12'h000
`define DMSC_SOF_BIT 0
`endif

// ==== design/dmsc_pkg.sv ====
// types of the deinterlacer mode and sync control
package dmsc_pkg;
    typedef enum logic [1:0] {ST_PASS, ST_ARMED, ST_LOCKED} dmsc_state_e;
    typedef logic [11:0] dmsc_dim_t;
    typedef enum logic {MODE_REPEAT, MODE_BLEND} dmsc_mode_e;
endpackage

// ==== design/dmsc_stall_wd.sv ====
// stall watchdog: one pulse when a stall outlasts a limit
`timescale 1ns/1ps
module dmsc_stall_wd #(
    parameter int LIMIT = 1000,
    parameter int CW = 11
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_en,
    input wire logic i_stall,
    output logic o_over
);
    initial begin
        if (LIMIT < 1 || LIMIT >= (1 << CW)) begin
            $error("dmsc_stall_wd: LIMIT does not fit CW");
        end
    end
    logic [CW-1:0] cnt_ff;
    logic over_ff;
    // saturates so one long stall gives one pulse only
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_ff <= '0;
        end else if (!i_stall || !i_en) begin
            cnt_ff <= '0;
        end else if (cnt_ff != CW'(LIMIT + 1)) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            over_ff <= 1'b0;
        end else begin
            over_ff <= i_en && i_stall && (cnt_ff == CW'(LIMIT));
        end
    end
    assign o_over = over_ff;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    wd_one_pulse_a: assert property (o_over |=> !o_over)
        else $error("watchdog pulse longer than one cycle");
endmodule // dmsc_stall_wd

// ==== design/dmsc_top.sv ====
// deinterlacer mode, frame lock and stream error control
`timescale 1ns/1ps
`include "dmsc_consts.svh"
module dmsc_top #(
    parameter int DW = 24,
    parameter bit EVAL_BUILD = 1'b0,
    parameter logic [39:0] EVAL_CYCLES = 40'(`DMSC_EVAL_CYCLES)
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ctl_rstn,
    input wire logic i_ctl_clken,
    input wire dmsc_pkg::dmsc_dim_t i_cfg_width,
    input wire dmsc_pkg::dmsc_dim_t i_cfg_height,
    input wire dmsc_pkg::dmsc_mode_e i_cfg_mode,
    input wire logic i_start,
    input wire logic i_err_clr,
    input wire logic i_in_en,
    input wire logic i_out_en,
    input wire logic [DW-1:0] i_s_tdata,
    input wire logic i_s_tvalid,
    input wire logic i_s_tuser,
    input wire logic i_s_tlast,
    input wire logic i_s_tactive,
    output logic o_s_tready,
    output logic [DW-1:0] o_m_tdata,
    output logic o_m_tvalid,
    output logic o_m_tuser,
    output logic o_m_tlast,
    input wire logic i_m_tready,
    output logic o_deint_lock,
    output logic o_lock_status,
    output logic o_lock_evt,
    output logic o_err_evt,
    output logic o_in_ovr_err,
    output logic o_out_ovr_err,
    output logic o_lock_lost,
    output logic o_expired
);
    import dmsc_pkg::*;
    initial begin
        if (DW < 2 || DW > 64) begin
            $error("dmsc_top: DW out of range");
        end
    end

    // ==========================================================
    // control side and lock state
    // ==========================================================
    dmsc_state_e state_ff;
    dmsc_dim_t width_ff;
    dmsc_dim_t height_ff;
    dmsc_mode_e mode_ff;
    dmsc_dim_t pix_cnt_ff;
    dmsc_dim_t line_cnt_ff;
    logic [DW-1:0] prev_ff;
    logic [DW-1:0] copy_ff;
    logic rep_ff;
    logic last_hold_ff;
    logic s_ready_ff;
    logic m_valid_ff;
    logic [DW-1:0] m_data_ff;
    logic m_user_ff;
    logic m_last_ff;
    logic lock_ff;
    logic lock_evt_ff;
    logic err_evt_ff;
    logic in_ovr_ff;
    logic out_ovr_ff;
    logic lost_ff;
    logic expired_ff;
    logic [39:0] run_cnt_ff;
    logic in_over;
    logic out_over;
    logic ctl_ok;
    logic acc;
    logic sof;
    logic line_bad;
    logic frame_bad;
    logic fault;
    logic m_take;

    assign ctl_ok = i_ctl_rstn && i_ctl_clken;
    assign acc = i_s_tvalid && s_ready_ff;
    assign sof = acc && i_s_tuser;
    assign m_take = m_valid_ff && i_m_tready;
    assign line_bad = acc && i_s_tactive && i_s_tlast && (pix_cnt_ff + 1'b1 != width_ff);
    assign frame_bad = sof && (line_cnt_ff != height_ff);
    assign fault = (state_ff == ST_LOCKED) && (line_bad || frame_bad);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= ST_PASS;
        end else begin
            case (state_ff)
                ST_PASS: begin
                    if (ctl_ok && i_start) begin
                        state_ff <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (!i_ctl_rstn) begin
                        state_ff <= ST_PASS;
                    end else if (sof) begin
                        state_ff <= ST_LOCKED;
                    end
                end
                ST_LOCKED: begin
                    if (fault) begin
                        state_ff <= ST_PASS;
                    end
                end
                default: begin
                    state_ff <= ST_PASS;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            width_ff <= `DMSC_DIM_RST;
            height_ff <= `DMSC_DIM_RST;
            mode_ff <= MODE_REPEAT;
        end else if (state_ff == ST_ARMED && sof) begin
            width_ff <= i_cfg_width;
            height_ff <= i_cfg_height;
            mode_ff <= i_cfg_mode;
        end
    end

    // raster tracking; frame start beat counts as pixel 0 of line 0
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pix_cnt_ff <= '0;
            line_cnt_ff <= '0;
        end else if (acc && i_s_tactive) begin
            if (i_s_tlast) begin
                pix_cnt_ff <= '0;
                line_cnt_ff <= i_s_tuser ? 12'h001 : line_cnt_ff + 1'b1;
            end else begin
                pix_cnt_ff <= pix_cnt_ff + 1'b1;
                if (i_s_tuser) begin
                    line_cnt_ff <= '0;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lock_ff <= 1'b0;
            lock_evt_ff <= 1'b0;
        end else begin
            lock_ff <= (state_ff == ST_ARMED && sof) || (state_ff == ST_LOCKED && !fault);
            lock_evt_ff <= state_ff == ST_ARMED && sof;
        end
    end

    // ==========================================================
    // datapath: one output stage, second copy when locked
    // ==========================================================
    // trade-off: no skid buffer, so pass-through peaks at one pixel per two clocks
    // stall and resume
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            m_valid_ff <= 1'b0;
            rep_ff <= 1'b0;
            m_data_ff <= '0;
            m_user_ff <= 1'b0;
            m_last_ff <= 1'b0;
            copy_ff <= '0;
            last_hold_ff <= 1'b0;
        end else if (acc && i_s_tactive) begin
            m_valid_ff <= 1'b1;
            m_data_ff <= expired_ff ? '0 : i_s_tdata;
            m_user_ff <= i_s_tuser;
            rep_ff <= state_ff == ST_LOCKED;
            m_last_ff <= i_s_tlast && state_ff != ST_LOCKED;
            last_hold_ff <= i_s_tlast;
            copy_ff <= (mode_ff == MODE_BLEND) ?
                DW'(({1'b0, i_s_tdata} + {1'b0, prev_ff}) >> 1) : i_s_tdata;
        end else if (m_take && rep_ff) begin
            rep_ff <= 1'b0;
            m_data_ff <= expired_ff ? '0 : copy_ff;
            m_user_ff <= 1'b0;
            m_last_ff <= last_hold_ff;
        end else if (m_take) begin
            m_valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_ff <= '0;
        end else if (acc && i_s_tactive) begin
            prev_ff <= i_s_tdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_ready_ff <= 1'b0;
        end else begin
            s_ready_ff <= !(acc && i_s_tactive) && (!m_valid_ff || (m_take && !rep_ff));
        end
    end

    // ==========================================================
    // overrun detection and error flags
    // ==========================================================
    // output stall watchdog
    dmsc_stall_wd #(.LIMIT(`DMSC_OUT_STALL_CLKS), .CW(11)) u_out_wd (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_en(i_out_en),
        .i_stall(m_valid_ff && !i_m_tready),
        .o_over(out_over)
    );
    dmsc_stall_wd #(.LIMIT(`DMSC_IN_STALL_CLKS), .CW(11)) u_in_wd (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_en(i_in_en),
        .i_stall(i_s_tvalid && !s_ready_ff),
        .o_over(in_over)
    );

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            in_ovr_ff <= 1'b0;
            out_ovr_ff <= 1'b0;
            lost_ff <= 1'b0;
        end else begin
            in_ovr_ff <= (in_over && i_in_en) || (in_ovr_ff && !i_err_clr);
            out_ovr_ff <= (out_over && i_out_en) || (out_ovr_ff && !i_err_clr);
            lost_ff <= fault || (lost_ff && !i_err_clr);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            err_evt_ff <= 1'b0;
        end else begin
            err_evt_ff <= (in_over && i_in_en) || (out_over && i_out_en) || fault;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            run_cnt_ff <= '0;
            expired_ff <= 1'b0;
        end else if (EVAL_BUILD && !expired_ff) begin
            run_cnt_ff <= run_cnt_ff + 1'b1;
            expired_ff <= run_cnt_ff + 1'b1 >= EVAL_CYCLES;
        end
    end

    assign o_s_tready = s_ready_ff;
    assign o_m_tdata = m_data_ff;
    assign o_m_tvalid = m_valid_ff;
    assign o_m_tuser = m_user_ff;
    assign o_m_tlast = m_last_ff;
    assign o_deint_lock = lock_ff;
    assign o_lock_status = lock_ff;
    assign o_lock_evt = lock_evt_ff;
    assign o_err_evt = err_evt_ff;
    assign o_in_ovr_err = in_ovr_ff;
    assign o_out_ovr_err = out_ovr_ff;
    assign o_lock_lost = lost_ff;
    assign o_expired = expired_ff;

    // ==========================================================
    // checks
    // ==========================================================
    logic [10:0] stall_cnt_ff;
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stall_cnt_ff <= '0;
        end else if (!(m_valid_ff && !i_m_tready && i_out_en)) begin
            stall_cnt_ff <= '0;
        end else if (stall_cnt_ff != 11'h7FF) begin
            stall_cnt_ff <= stall_cnt_ff + 1'b1;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_frame_start;
        state_ff == ST_ARMED && sof;
    endsequence
    sequence s_locked_pin;
        o_deint_lock && o_lock_status && o_lock_evt;
    endsequence

    lock_at_sof_a: assert property ($rose(o_deint_lock) |-> $past(sof))
        else $error("lock rose without frame start");
    lock_three_a: assert property (s_frame_start |=> s_locked_pin)
        else $error("lock not shown on pin, event and status");
    pix_double_a: assert property ((acc && i_s_tactive && state_ff == ST_LOCKED)
        |=> o_m_tvalid && rep_ff)
        else $error("locked pixel not doubled");
    blank_drop_a: assert property ((acc && !i_s_tactive && !m_valid_ff)
        |=> !o_m_tvalid)
        else $error("blanking beat reached output");
    out_hold_a: assert property ((o_m_tvalid && !i_m_tready)
        |=> o_m_tvalid && $stable(o_m_tdata))
        else $error("output changed while stalled");
    out_ovr_a: assert property ((stall_cnt_ff == 11'd1001) |=> ##1 o_out_ovr_err)
        else $error("output overrun not flagged after 1000 clocks");
    port_gate_a: assert property ($rose(o_in_ovr_err) |-> $past(i_in_en))
        else $error("input overrun on a disabled port");
    fault_show_a: assert property ($fell(o_deint_lock) && !$past(i_err_clr)
        |-> o_lock_lost)
        else $error("lock dropped without fault flag");
    eval_zero_a: assert property ((o_expired && o_m_tvalid && $past(o_expired))
        |-> o_m_tdata == '0)
        else $error("pixels not zero after timeout");
    ctl_gate_a: assert property ((state_ff == ST_PASS && !ctl_ok)
        |=> state_ff == ST_PASS)
        else $error("start taken while control side disabled");
endmodule // dmsc_top

// ==== dv/dmsc_vid_partner.sv ====
// upstream video source and downstream video sink model
`timescale 1ns/1ps
module dmsc_vid_partner #(
    parameter int DW = 24
) (
    input wire logic i_core_clk,
    input wire logic i_s_tready,
    output logic [DW-1:0] o_s_tdata,
    output logic o_s_tvalid,
    output logic o_s_tuser,
    output logic o_s_tlast,
    output logic o_s_tactive,
    input wire logic [DW-1:0] i_m_tdata,
    input wire logic i_m_tvalid,
    output logic o_m_tready,
    input wire logic i_stall
);
    logic [DW-1:0] got_q[$];

    // sink withholds ready on demand to build a backlog
    assign o_m_tready = !i_stall;

    initial begin
        o_s_tdata = '0;
        o_s_tvalid = 1'b0;
        o_s_tuser = 1'b0;
        o_s_tlast = 1'b0;
        o_s_tactive = 1'b0;
    end

    always @(posedge i_core_clk) begin
        if (i_m_tvalid && o_m_tready) begin
            got_q.push_back(i_m_tdata);
        end
    end

    // beat held until taken
    // called just after an edge; ready is settled then and holds to the next edge
    task automatic send(input logic [DW-1:0] d, input logic u, input logic l, input logic a);
        o_s_tdata = d;
        o_s_tuser = u;
        o_s_tlast = l;
        o_s_tactive = a;
        o_s_tvalid = 1'b1;
        // a ready that never comes is caught by the bench timeout
        while (i_s_tready !== 1'b1) begin
            @(posedge i_core_clk);
            #1;
        end
        @(posedge i_core_clk);
        #1;
        // released data shows the inverse, never a stale copy
        o_s_tvalid = 1'b0;
        o_s_tdata = ~d;
        o_s_tuser = ~u;
        o_s_tlast = ~l;
        // one idle edge so a following beat never re-raises valid in this step
        @(posedge i_core_clk);
        #1;
    endtask
endmodule // dmsc_vid_partner

// ==== dv/tb.sv ====
// self-checking bench of the deinterlacer mode and sync control
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb;
    import dmsc_pkg::*;
    logic clk, rstn, ctl_rstn, ctl_clken, start, err_clr, in_en, out_en, stall;
    dmsc_dim_t cfg_w, cfg_h;
    dmsc_mode_e cfg_mode;
    logic [23:0] s_tdata, m_tdata;
    logic s_tvalid, s_tuser, s_tlast, s_tactive, s_tready, m_tvalid, m_tuser, m_tlast, m_tready;
    logic deint_lock, lock_status, lock_evt, err_evt, in_ovr, out_ovr, lock_lost, expired;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int lock_n = 0;
    int err_n = 0;
    logic [1:0] ul_q[$];

    // eval limit cut short so expiry lands inside the run
    dmsc_top #(.DW(24), .EVAL_BUILD(1'b1), .EVAL_CYCLES(40'd20000)) dmsc_top_i (
        .i_core_clk(clk), .i_rstn(rstn), .i_ctl_rstn(ctl_rstn), .i_ctl_clken(ctl_clken),
        .i_cfg_width(cfg_w), .i_cfg_height(cfg_h), .i_cfg_mode(cfg_mode), .i_start(start),
        .i_err_clr(err_clr), .i_in_en(in_en), .i_out_en(out_en), .i_s_tdata(s_tdata),
        .i_s_tvalid(s_tvalid), .i_s_tuser(s_tuser), .i_s_tlast(s_tlast),
        .i_s_tactive(s_tactive), .o_s_tready(s_tready), .o_m_tdata(m_tdata),
        .o_m_tvalid(m_tvalid), .o_m_tuser(m_tuser), .o_m_tlast(m_tlast),
        .i_m_tready(m_tready), .o_deint_lock(deint_lock), .o_lock_status(lock_status),
        .o_lock_evt(lock_evt), .o_err_evt(err_evt), .o_in_ovr_err(in_ovr),
        .o_out_ovr_err(out_ovr), .o_lock_lost(lock_lost), .o_expired(expired));

    dmsc_vid_partner #(.DW(24)) dmsc_vid_partner_i (
        .i_core_clk(clk), .i_s_tready(s_tready), .o_s_tdata(s_tdata), .o_s_tvalid(s_tvalid),
        .o_s_tuser(s_tuser), .o_s_tlast(s_tlast), .o_s_tactive(s_tactive),
        .i_m_tdata(m_tdata), .i_m_tvalid(m_tvalid), .o_m_tready(m_tready), .i_stall(stall));

    // ==========================================
    // clock, event counters, timeout
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (lock_evt === 1'b1) lock_n++;
        if (err_evt === 1'b1) err_n++;
        if (m_tvalid === 1'b1 && m_tready === 1'b1) ul_q.push_back({m_tuser, m_tlast});
        if (cyc == 30000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic beat(input logic [23:0] d, input logic u, input logic l, input logic a);
        dmsc_vid_partner_i.send(d, u, l, a);
    endtask

    task automatic flush();
        dmsc_vid_partner_i.got_q.delete();
        ul_q.delete();
    endtask

    function automatic int qsz();
        return dmsc_vid_partner_i.got_q.size();
    endfunction

    function automatic logic [23:0] qat(input int i);
        return dmsc_vid_partner_i.got_q[i];
    endfunction

    // two lines of two pixels
    task automatic frame(input logic [23:0] b);
        beat(b, 1'b1, 1'b0, 1'b1);
        beat(b + 24'h1, 1'b0, 1'b1, 1'b1);
        beat(b + 24'h2, 1'b0, 1'b0, 1'b1);
        beat(b + 24'h3, 1'b0, 1'b1, 1'b1);
        step(4);
    endtask

    task automatic pulse_start();
        start = 1'b1;
        step(1);
        start = 1'b0;
        step(1);
    endtask

    // one beat parked at the output, a second left waiting at the input
    task automatic jam(input logic en);
        flush();
        stall = 1'b1;
        beat(24'h111111, 1'b0, 1'b0, 1'b1);
        in_en = en;
        out_en = en;
        fork
            beat(24'h222222, 1'b0, 1'b0, 1'b1);
        join_none
        step(995);
    endtask

    task automatic unjam();
        stall = 1'b0;
        in_en = 1'b1;
        out_en = 1'b1;
        wait fork;
        step(4);
    endtask

    // ==========================================
    // scenarios
    task automatic t_pass();
        flush();
        beat(24'hA5A5A5, 1'b1, 1'b0, 1'b1);
        beat(24'h3C3C3C, 1'b0, 1'b0, 1'b0);
        beat(24'h0F0F0F, 1'b0, 1'b1, 1'b1);
        step(4);
        `CHK(qsz(), 2)
        `CHK(qat(0), 24'hA5A5A5)
        `CHK(qat(1), 24'h0F0F0F)
        `CHK(ul_q[0], 2'b10)
        `CHK(ul_q[1], 2'b01)
        `CHK(deint_lock, 1'b0)
    endtask

    task automatic t_stall_off();
        jam(1'b0);
        step(110);
        `CHK(out_ovr, 1'b0)
        `CHK(in_ovr, 1'b0)
        `CHK(err_n, 0)
        unjam();
    endtask

    task automatic t_stall_on();
        int e0;
        e0 = err_n;
        jam(1'b1);
        `CHK(out_ovr, 1'b0)
        `CHK(in_ovr, 1'b0)
        step(15);
        `CHK(out_ovr, 1'b1)
        `CHK(in_ovr, 1'b1)
        `CHK(err_n > e0, 1'b1)
        `CHK(m_tdata, 24'h111111)
        unjam();
        `CHK(qsz(), 2)
        `CHK(qat(1), 24'h222222)
        err_clr = 1'b1;
        step(1);
        err_clr = 1'b0;
        step(1);
        `CHK(out_ovr, 1'b0)
    endtask

    task automatic t_lock();
        ctl_clken = 1'b0;
        pulse_start();
        frame(24'h000010);
        `CHK(deint_lock, 1'b0)
        ctl_clken = 1'b1;
        ctl_rstn = 1'b0;
        pulse_start();
        frame(24'h000010);
        `CHK(deint_lock, 1'b0)
        ctl_rstn = 1'b1;
        step(1);
        pulse_start();
        `CHK(deint_lock, 1'b0)
        frame(24'h000010);
        `CHK(deint_lock, 1'b1)
        `CHK(lock_status, 1'b1)
        `CHK(lock_n, 1)
        flush();
        frame(24'h000020);
        `CHK(qsz(), 8)
        for (int i = 0; i < 8; i++) `CHK(qat(i), 24'h000020 + 24'(i / 2))
        for (int i = 0; i < 8; i++) `CHK(ul_q[i], (i == 0) ? 2'b10 : ((i % 4 == 3) ? 2'b01 : 2'b00))
    endtask

    task automatic t_fault();
        int e0;
        e0 = err_n;
        beat(24'h000030, 1'b1, 1'b0, 1'b1);
        beat(24'h000031, 1'b0, 1'b0, 1'b1);
        beat(24'h000032, 1'b0, 1'b1, 1'b1);
        step(4);
        `CHK(deint_lock, 1'b0)
        `CHK(lock_lost, 1'b1)
        `CHK(in_ovr, 1'b0)
        `CHK(err_n > e0, 1'b1)
        cfg_mode = MODE_BLEND;
        pulse_start();
        frame(24'h000040);
        `CHK(lock_n, 2)
        flush();
        frame(24'h000040);
        `CHK(qsz(), 8)
        `CHK(qat(0), 24'h000040)
        `CHK(qat(1), 24'h000041)
        `CHK(qat(3), 24'h000040)
        `CHK(qat(7), 24'h000042)
    endtask

    task automatic t_eval();
        while (expired !== 1'b1 && cyc < 25000) step(1);
        `CHK(expired, 1'b1)
        flush();
        beat(24'h5A5A5A, 1'b0, 1'b0, 1'b1);
        step(4);
        `CHK(qat(0), 24'h000000)
        `CHK(qat(1), 24'h000000)
    endtask

    // ==========================================
    // main sequence
    initial begin
        rstn = 1'b0;
        ctl_rstn = 1'b1;
        ctl_clken = 1'b1;
        start = 1'b0;
        err_clr = 1'b0;
        in_en = 1'b1;
        out_en = 1'b1;
        stall = 1'b0;
        cfg_w = 12'h002;
        cfg_h = 12'h002;
        cfg_mode = MODE_REPEAT;
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
        step(2);
        t_pass();
        t_stall_off();
        t_stall_on();
        t_lock();
        t_fault();
        t_eval();
        finish_test();
    end
endmodule // tb
